// ===== rtl/cmsa_pkg.sv
package cmsa_pkg;
    // Reset values of the three source settings
    localparam logic [15:0] START_SEL_RST = 16'h0000;
    localparam logic [15:0] FREQ_SEL_RST  = 16'h0000;
    localparam logic [15:0] KPAD_SEL_RST  = 16'h270F;
    // Setting values
    localparam logic [15:0] SRC_SERIAL    = 16'h0000;
    localparam logic [15:0] SRC_TERM      = 16'h0001;
    localparam logic [15:0] FREQ_TERM_FB  = 16'h0002;
    localparam logic [15:0] KPAD_SERIAL   = 16'h0002;
    localparam logic [15:0] KPAD_PANEL    = 16'h0004;
    localparam logic [15:0] KPAD_AUTO     = 16'h270F;
    localparam logic [15:0] WPERM_ALWAYS  = 16'h0002;
    localparam logic [15:0] XDISP_OPEN    = 16'h0000;

    // Which setting a write targets
    typedef enum logic [1:0] {
        SEL_START = 2'h0,
        SEL_FREQ  = 2'h1,
        SEL_KPAD  = 2'h2
    } cmsa_set_e;

    // Operation modes, Gray along keypad-terminal-combined-network
    typedef enum logic [2:0] {
        M_KPAD  = 3'h0,
        M_TERM  = 3'h1,
        M_COMB3 = 3'h3,
        M_COMB4 = 3'h2,
        M_NET   = 3'h6
    } cmsa_mode_e;

    // Keypad-mode command source
    typedef enum logic [1:0] {
        KS_PANEL    = 2'h0,
        KS_HANDHELD = 2'h1,
        KS_SERIAL   = 2'h3
    } cmsa_ksrc_e;

    // Frequency command source
    typedef enum logic [1:0] {
        F_NONE   = 2'h0,
        F_SERIAL = 2'h1,
        F_TERM   = 2'h3,
        F_KPAD   = 2'h2
    } cmsa_fsrc_e;

    // Command bundle: requests, grants or refusals
    typedef struct packed {
        logic start;
        logic stop;
        logic freq;
        logic write;
        logic rst;
        logic clear;
    } cmsa_cmd_s;

    // Control terminal pins
    typedef struct packed {
        logic start;
        logic stop;
        logic rst;
        logic freq_present;
        logic multispeed;
        logic t45_sel;
    } cmsa_term_s;

    // Setting write request
    typedef struct packed {
        logic        req;
        cmsa_set_e   sel;
        logic [15:0] data;
    } cmsa_swr_s;
endpackage

// ===== rtl/cmsa_arbiter.sv
`timescale 1ns/1ns
module cmsa_arbiter (
    // Clock, reset, enable
    input  wire logic                clk_sys_in,
    input  wire logic                rst_b_in,
    input  wire logic                clk_en_in,
    // Drive configuration
    input  wire cmsa_pkg::cmsa_mode_e op_mode_in,
    input  wire logic [15:0]         write_permission_select_in,
    input  wire logic [15:0]         extended_display_select_in,
    input  wire logic                drive_reset_in,
    input  wire logic                keypad_stop_active_in,
    // Serial link requests
    input  wire cmsa_pkg::cmsa_cmd_s  ser_req_in,
    input  wire logic                ser_wr_exempt_in,
    input  wire logic                ser_comm_err_in,
    input  wire logic                net_switch_req_in,
    input  wire logic                read_req_in,
    // Pins
    input  wire cmsa_pkg::cmsa_term_s term_pins_in,
    input  wire logic                handheld_present_in,
    // Setting writes
    input  wire cmsa_pkg::cmsa_swr_s  set_wr_in,
    // Grants and refusals
    output cmsa_pkg::cmsa_cmd_s      ser_grant_out,
    output cmsa_pkg::cmsa_cmd_s      ser_refuse_out,
    output cmsa_pkg::cmsa_cmd_s      term_grant_out,
    output cmsa_pkg::cmsa_fsrc_e     freq_src_out,
    output logic                     t2_ignore_out,
    output logic                     net_switch_ok_out,
    output logic                     net_switch_refuse_out,
    output logic                     modbus_ok_out,
    output logic                     read_grant_out,
    // Panel indication
    output cmsa_pkg::cmsa_ksrc_e     keypad_src_out,
    output logic                     mode_indicator_lamps_out,
    output logic                     keypad_stop_indication_out,
    // Setting state
    output logic                     set_wr_ack_out,
    output logic                     set_wr_nak_out,
    output logic [15:0]              start_source_select_out,
    output logic [15:0]              frequency_source_select_out,
    output logic [15:0]              keypad_mode_source_select_out,
    output logic [15:0]              keypad_active_out
);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int PW = $bits(cmsa_pkg::cmsa_term_s) + 1;
    logic [PW-1:0] pin_s1_reg;
    logic [PW-1:0] pin_s2_reg;

    // Two stages; only the second is read
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else if (clk_en_in) begin
            pin_s1_reg <= {term_pins_in, handheld_present_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    cmsa_pkg::cmsa_term_s term;
    wire hh_present = pin_s2_reg[0];
    assign term = pin_s2_reg[PW-1:1];

    ////////////////////////////////////////////////////////////////
    // Stored and latched settings
    logic [15:0] start_sel_reg;
    logic [15:0] freq_sel_reg;
    logic [15:0] kpad_sel_reg;
    logic [15:0] kpad_act_reg;
    logic        boot_reg;

    // Write qualification
    wire xdisp_ok   = extended_display_select_in == cmsa_pkg::XDISP_OPEN;
    wire [15:0] wd  = set_wr_in.data;
    wire start_rng  = wd == cmsa_pkg::SRC_SERIAL || wd == cmsa_pkg::SRC_TERM;
    wire freq_rng   = start_rng || wd == cmsa_pkg::FREQ_TERM_FB;
    wire kpad_rng   = wd == cmsa_pkg::KPAD_SERIAL || wd == cmsa_pkg::KPAD_PANEL
                   || wd == cmsa_pkg::KPAD_AUTO;
    wire sel_start  = set_wr_in.sel == cmsa_pkg::SEL_START;
    wire sel_freq   = set_wr_in.sel == cmsa_pkg::SEL_FREQ;
    wire sel_kpad   = set_wr_in.sel == cmsa_pkg::SEL_KPAD;
    // Keypad setting ignores mode and write permission
    wire rng_ok     = (sel_start && start_rng) || (sel_freq && freq_rng)
                   || (sel_kpad && kpad_rng);
    wire wr_take    = set_wr_in.req && xdisp_ok && rng_ok;
    wire wr_drop    = set_wr_in.req && !wr_take;

    // Latch the keypad setting after power-on, drive_reset_in or a granted serial reset
    wire ser_rst_ok;
    wire latch_now  = boot_reg || drive_reset_in || ser_rst_ok;

    // Setting store; rejected values leave it untouched
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_sel_reg <= cmsa_pkg::START_SEL_RST;
            freq_sel_reg  <= cmsa_pkg::FREQ_SEL_RST;
            kpad_sel_reg  <= cmsa_pkg::KPAD_SEL_RST;
        end else if (clk_en_in && wr_take) begin
            if (sel_start)
                start_sel_reg <= wd;
            if (sel_freq)
                freq_sel_reg  <= wd;
            if (sel_kpad)
                kpad_sel_reg  <= wd;
        end
    end

    // Active keypad selection; written only by a reset event
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            kpad_act_reg <= cmsa_pkg::KPAD_SEL_RST;
            boot_reg     <= 1'b1;
        end else if (clk_en_in) begin
            boot_reg <= 1'b0;
            if (latch_now)
                kpad_act_reg <= kpad_sel_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode decode
    wire m_kpad  = op_mode_in == cmsa_pkg::M_KPAD;
    wire m_term  = op_mode_in == cmsa_pkg::M_TERM;
    wire m_comb3 = op_mode_in == cmsa_pkg::M_COMB3;
    wire m_comb4 = op_mode_in == cmsa_pkg::M_COMB4;
    wire m_net   = op_mode_in == cmsa_pkg::M_NET;
    wire kp2     = kpad_act_reg == cmsa_pkg::KPAD_SERIAL;
    wire kp4     = kpad_act_reg == cmsa_pkg::KPAD_PANEL;
    wire st_ser  = start_sel_reg == cmsa_pkg::SRC_SERIAL;
    wire st_term = start_sel_reg == cmsa_pkg::SRC_TERM;
    wire fq_ser  = freq_sel_reg == cmsa_pkg::SRC_SERIAL;
    wire fq_fb   = freq_sel_reg == cmsa_pkg::FREQ_TERM_FB;
    wire fq_term = freq_sel_reg == cmsa_pkg::SRC_TERM || fq_fb;
    wire t_pres  = term.freq_present;

    ////////////////////////////////////////////////////////////////
    // Serial permissions
    // Keypad setting 2: per-mode table, nothing in network
    wire k_start = m_kpad || m_comb4;
    wire k_stop  = k_start || ((m_term || m_comb3) && keypad_stop_active_in);
    wire k_freq  = m_kpad || m_comb3;
    wire k_wbase = m_kpad || m_comb3 || m_comb4;
    wire k_rst   = !m_net;
    // Other settings: network only, steered by the source settings
    wire n_start = m_net && st_ser;
    wire n_freq  = m_net && (fq_ser || (fq_fb && !t_pres));
    wire n_wbase = m_net;
    wire w_base  = kp2 ? k_wbase : n_wbase;
    // Exempt parameters pass in any mode; permission 2 passes all writes
    wire w_force = write_permission_select_in == cmsa_pkg::WPERM_ALWAYS;

    cmsa_pkg::cmsa_cmd_s ser_ok;
    assign ser_ok.start = kp2 ? k_start : n_start;
    assign ser_ok.stop  = kp2 ? k_stop : n_start;
    assign ser_ok.freq  = kp2 ? k_freq : n_freq;
    assign ser_ok.write = w_base || ser_wr_exempt_in || w_force;
    assign ser_ok.rst   = (kp2 ? k_rst : m_net) && !ser_comm_err_in;
    assign ser_ok.clear = w_base;
    assign ser_rst_ok   = ser_req_in.rst && ser_ok.rst;

    ////////////////////////////////////////////////////////////////
    // Terminal permissions
    wire t_run  = m_term || m_comb3 || (m_net && st_term);
    wire t_freq = m_term || m_comb4 || (m_net && fq_term && t_pres)
               || (m_comb3 && (term.multispeed || term.t45_sel));

    cmsa_pkg::cmsa_cmd_s term_ok;
    assign term_ok.start = t_run && term.start;
    assign term_ok.stop  = t_run && term.stop;
    assign term_ok.freq  = t_freq && t_pres;
    assign term_ok.write = 1'b0;
    assign term_ok.rst   = term.rst;
    assign term_ok.clear = 1'b0;

    ////////////////////////////////////////////////////////////////
    // Frequency source and panel source
    cmsa_pkg::cmsa_fsrc_e fsrc;
    assign fsrc = term_ok.freq ? cmsa_pkg::F_TERM
                : ser_ok.freq ? cmsa_pkg::F_SERIAL
                : (m_kpad || m_comb3) ? cmsa_pkg::F_KPAD
                : cmsa_pkg::F_NONE;
    wire t2_ign = m_net && fq_fb && !t_pres;

    // Serial traffic never enters this choice
    cmsa_pkg::cmsa_ksrc_e ksrc;
    assign ksrc = kp2 ? cmsa_pkg::KS_SERIAL
                : kp4 ? cmsa_pkg::KS_PANEL
                : hh_present ? cmsa_pkg::KS_HANDHELD
                : cmsa_pkg::KS_PANEL;

    ////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ser_grant_out              <= '0;
            ser_refuse_out             <= '0;
            term_grant_out             <= '0;
            freq_src_out               <= cmsa_pkg::F_NONE;
            t2_ignore_out              <= 1'b0;
            net_switch_ok_out          <= 1'b0;
            net_switch_refuse_out      <= 1'b0;
            modbus_ok_out              <= 1'b0;
            read_grant_out             <= 1'b0;
            keypad_src_out             <= cmsa_pkg::KS_PANEL;
            mode_indicator_lamps_out   <= 1'b0;
            keypad_stop_indication_out <= 1'b0;
            set_wr_ack_out             <= 1'b0;
            set_wr_nak_out             <= 1'b0;
        end else if (clk_en_in) begin
            ser_grant_out              <= ser_req_in & ser_ok;
            ser_refuse_out             <= ser_req_in & ~ser_ok;
            term_grant_out             <= term_ok;
            freq_src_out               <= fsrc;
            t2_ignore_out              <= t2_ign;
            net_switch_ok_out          <= net_switch_req_in && !kp2;
            net_switch_refuse_out      <= net_switch_req_in && kp2;
            modbus_ok_out              <= m_net && !kp2;
            read_grant_out             <= read_req_in;
            keypad_src_out             <= ksrc;
            mode_indicator_lamps_out   <= ksrc == cmsa_pkg::KS_PANEL;
            keypad_stop_indication_out <= keypad_stop_active_in;
            set_wr_ack_out             <= wr_take;
            set_wr_nak_out             <= wr_drop;
        end
    end

    // Setting views follow their registers directly
    assign start_source_select_out       = start_sel_reg;
    assign frequency_source_select_out   = freq_sel_reg;
    assign keypad_mode_source_select_out = kpad_sel_reg;
    assign keypad_active_out             = kpad_act_reg;

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence s_latch;
        clk_en_in && latch_now;
    endsequence
    sequence s_kp_write;
        clk_en_in && wr_take && sel_kpad && !latch_now;
    endsequence

    a_kpad_latch: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_latch |=> keypad_active_out == $past(kpad_sel_reg))
        else $error("keypad selection not latched on reset");
    a_kpad_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_kp_write |=> $stable(keypad_active_out))
        else $error("keypad selection changed without reset");
    a_net_refuse: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && net_switch_req_in && kp2 |=> net_switch_refuse_out && !net_switch_ok_out)
        else $error("network switch not refused");
    a_comm_err_rst: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && ser_comm_err_in && ser_req_in.rst |=> ser_refuse_out.rst && !ser_grant_out.rst)
        else $error("reset taken during comm error");
    a_net_only: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && !kp2 && !m_net && ser_req_in.start |=> !ser_grant_out.start)
        else $error("serial start outside network");
    a_kp2_net: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && kp2 && m_net && ser_req_in.freq |=> ser_refuse_out.freq)
        else $error("serial frequency taken in network");
    a_lamps_off: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && (kp2 || (!kp4 && kpad_act_reg == cmsa_pkg::KPAD_AUTO && hh_present))
        |=> !mode_indicator_lamps_out)
        else $error("lamps on with foreign source");
    a_hh_prio: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && kpad_act_reg == cmsa_pkg::KPAD_AUTO && hh_present
        |=> keypad_src_out == cmsa_pkg::KS_HANDHELD)
        else $error("handheld not preferred");
    a_xdisp_block: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && set_wr_in.req && !xdisp_ok |=> set_wr_nak_out && $stable(start_sel_reg)
        && $stable(freq_sel_reg) && $stable(kpad_sel_reg))
        else $error("setting written with extended display set");
    a_term_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clk_en_in && term.rst |=> term_grant_out.rst)
        else $error("terminal reset not accepted");

endmodule

// ===== tb/cmsa_host_model.sv
`timescale 1ns/1ns
// Serial host on the far side: one-cycle request pulses, launched after a falling edge
module cmsa_host_model (
    // Clock
    input  wire logic          clk_sys_in,
    // Requests towards the arbiter
    output cmsa_pkg::cmsa_cmd_s ser_req_out,
    output logic                net_switch_req_out,
    output logic                read_req_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle lines at time zero, so no request is seen before reset ends
    initial begin
        ser_req_out        = '0;
        net_switch_req_out = 1'b0;
        read_req_out       = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One transfer: held for exactly one rising edge, then released
    // Host asks for network mode before any MODBUS framing
    // Reads may be sent in every mode, whoever holds authority
    task automatic send(input cmsa_pkg::cmsa_cmd_s c, input logic net, input logic rd);
        @(negedge clk_sys_in);
        ser_req_out        = c;
        net_switch_req_out = net;
        read_req_out       = rd;
        @(negedge clk_sys_in);
        ser_req_out        = '0;
        net_switch_req_out = 1'b0;
        read_req_out       = 1'b0;
    endtask
endmodule

// ===== tb/command_source_arbiter_tb.sv
`timescale 1ns/1ns
module command_source_arbiter_tb;
    logic                     clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, drv_rst = 1'b0;
    logic                     kstop = 1'b0, exempt = 1'b0, comm_err = 1'b0, hh = 1'b0;
    logic [15:0]              wperm = 16'h0000, xdisp = 16'h0000;
    cmsa_pkg::cmsa_mode_e     op_mode = cmsa_pkg::M_KPAD;
    cmsa_pkg::cmsa_term_s     pins = '0;
    cmsa_pkg::cmsa_swr_s      set_wr = '0;
    cmsa_pkg::cmsa_cmd_s      ser_req, ser_gr, ser_rf, term_gr;
    cmsa_pkg::cmsa_fsrc_e     fsrc;
    cmsa_pkg::cmsa_ksrc_e     ksrc;
    logic                     net_req, rd_req, t2_ign, net_ok, net_rf, mb_ok, rd_gr, lamps, kstop_ind, ack, nak;
    logic [15:0]              st_sel, fr_sel, kp_sel, kp_act;
    int                       n_errors = 0, checks_done = 0;
    cmsa_pkg::cmsa_mode_e     modes [5] = '{cmsa_pkg::M_KPAD, cmsa_pkg::M_TERM, cmsa_pkg::M_COMB3,
                                            cmsa_pkg::M_COMB4, cmsa_pkg::M_NET};
    logic [5:0]               kp2_tab [5] = '{6'h3F, 6'h02, 6'h0F, 6'h37, 6'h00};
    logic [5:0]               kp4_tab [5] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h3F};
    logic [5:0]               term_tab [5] = '{6'h02, 6'h3A, 6'h32, 6'h0A, 6'h02};

    ////////////////////////////////////////////////////////////////////////////
    // Design and serial host
    cmsa_arbiter dut_u (.clk_sys_in(clk), .rst_b_in(rst_b), .clk_en_in(clk_en), .op_mode_in(op_mode),
        .write_permission_select_in(wperm), .extended_display_select_in(xdisp), .drive_reset_in(drv_rst),
        .keypad_stop_active_in(kstop), .ser_req_in(ser_req), .ser_wr_exempt_in(exempt),
        .ser_comm_err_in(comm_err), .net_switch_req_in(net_req), .read_req_in(rd_req),
        .term_pins_in(pins), .handheld_present_in(hh), .set_wr_in(set_wr), .ser_grant_out(ser_gr),
        .ser_refuse_out(ser_rf), .term_grant_out(term_gr), .freq_src_out(fsrc), .t2_ignore_out(t2_ign),
        .net_switch_ok_out(net_ok), .net_switch_refuse_out(net_rf), .modbus_ok_out(mb_ok),
        .read_grant_out(rd_gr), .keypad_src_out(ksrc), .mode_indicator_lamps_out(lamps),
        .keypad_stop_indication_out(kstop_ind), .set_wr_ack_out(ack), .set_wr_nak_out(nak),
        .start_source_select_out(st_sel), .frequency_source_select_out(fr_sel),
        .keypad_mode_source_select_out(kp_sel), .keypad_active_out(kp_act));
    cmsa_host_model host_u (.clk_sys_in(clk), .ser_req_out(ser_req), .net_switch_req_out(net_req),
        .read_req_out(rd_req));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the run needs well under 1000 cycles
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #300000;
        n_errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers: compare, setting write, serial request, re-latch
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_set(input cmsa_pkg::cmsa_set_e s, input logic [15:0] d, input logic ok);
        @(negedge clk);
        set_wr = {1'b1, s, d};
        @(negedge clk);
        set_wr.req = 1'b0;
        chk(ack, ok);
        chk(nak, !ok);
    endtask
    task automatic ser(input logic [5:0] rq, input logic [5:0] gr);
        host_u.send(rq, 1'b0, 1'b0);
        chk(ser_gr, gr);
        chk(ser_rf, rq & ~gr);
    endtask
    task automatic relatch(input logic [15:0] kp);
        wr_set(cmsa_pkg::SEL_KPAD, kp, 1'b1);
        chk(kp_sel, kp);
        @(negedge clk);
        drv_rst = 1'b1;
        @(negedge clk);
        drv_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(kp_act, kp);
    endtask
    task automatic wait_pins();
        repeat (4) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk(st_sel, cmsa_pkg::START_SEL_RST);
        chk(fr_sel, cmsa_pkg::FREQ_SEL_RST);
        chk(kp_sel, 16'h270F);
        chk(kp_act, 16'h270F);
        chk(ksrc, cmsa_pkg::KS_PANEL);
        $display("test reset_values finished");
        // Range and display gating; store stays put on refusal
        xdisp = 16'h0001;
        wr_set(cmsa_pkg::SEL_START, 16'h0001, 1'b0);
        xdisp = 16'h0000;
        wr_set(cmsa_pkg::SEL_START, 16'h0002, 1'b0);
        wr_set(cmsa_pkg::SEL_FREQ, 16'h0003, 1'b0);
        wr_set(cmsa_pkg::SEL_KPAD, 16'h0003, 1'b0);
        chk(st_sel, cmsa_pkg::START_SEL_RST);
        chk(fr_sel, cmsa_pkg::FREQ_SEL_RST);
        chk(kp_sel, 16'h270F);
        op_mode = cmsa_pkg::M_TERM;
        wr_set(cmsa_pkg::SEL_KPAD, 16'h270F, 1'b1);
        $display("test setting_writes finished");
        // Terminal authority per mode
        pins = 6'b111100;
        foreach (modes[i]) begin
            op_mode = modes[i];
            wait_pins();
            chk(term_gr, term_tab[i]);
        end
        // Combined mode 3 takes a terminal frequency only with multi-speed or t45_sel
        op_mode = cmsa_pkg::M_COMB3;
        pins = 6'b000110;
        wait_pins();
        chk(term_gr, 6'h08);
        chk(fsrc, cmsa_pkg::F_TERM);
        pins = 6'b000000;
        $display("test terminal_authority finished");
        // Automatic recognition: handheld wins, serial traffic does not
        op_mode = cmsa_pkg::M_KPAD;
        hh = 1'b1;
        wait_pins();
        chk(ksrc, cmsa_pkg::KS_HANDHELD);
        chk(lamps, 1'b0);
        chk(fsrc, cmsa_pkg::F_KPAD);
        ser(6'h20, 6'h00);
        hh = 1'b0;
        wait_pins();
        chk(ksrc, cmsa_pkg::KS_PANEL);
        chk(lamps, 1'b1);
        host_u.send('0, 1'b1, 1'b1);
        chk({rd_gr, net_ok, net_rf}, 16'h0006);
        $display("test auto_recognition finished");
        // Panel setting: serial only in network mode, except forced or exempt writes
        relatch(16'h0004);
        chk({ksrc, lamps}, 16'h0001);
        foreach (modes[i]) begin
            op_mode = modes[i];
            ser(6'h3F, kp4_tab[i]);
        end
        @(negedge clk);
        chk(mb_ok, 1'b1);
        st_sel_write: begin
            wr_set(cmsa_pkg::SEL_START, cmsa_pkg::SRC_TERM, 1'b1);
            chk(st_sel, cmsa_pkg::SRC_TERM);
            ser(6'h30, 6'h00);
            wr_set(cmsa_pkg::SEL_FREQ, cmsa_pkg::SRC_TERM, 1'b1);
            ser(6'h08, 6'h00);
            wr_set(cmsa_pkg::SEL_FREQ, cmsa_pkg::FREQ_TERM_FB, 1'b1);
            ser(6'h08, 6'h08);
            chk(t2_ign, 1'b1);
            chk(fsrc, cmsa_pkg::F_SERIAL);
        end
        op_mode = cmsa_pkg::M_TERM;
        wperm = cmsa_pkg::WPERM_ALWAYS;
        ser(6'h05, 6'h04);
        wperm = 16'h0000;
        exempt = 1'b1;
        ser(6'h04, 6'h04);
        exempt = 1'b0;
        $display("test panel_source finished");
        // Serial connector setting: table of serial permissions
        relatch(16'h0002);
        chk({ksrc, lamps}, 16'h0006);
        host_u.send('0, 1'b1, 1'b0);
        chk({net_ok, net_rf}, 16'h0001);
        foreach (modes[i]) begin
            op_mode = modes[i];
            ser(6'h3F, kp2_tab[i]);
        end
        @(negedge clk);
        chk(mb_ok, 1'b0);
        op_mode = cmsa_pkg::M_TERM;
        kstop = 1'b1;
        ser(6'h10, 6'h10);
        chk(kstop_ind, 1'b1);
        kstop = 1'b0;
        op_mode = cmsa_pkg::M_KPAD;
        comm_err = 1'b1;
        ser(6'h02, 6'h00);
        comm_err = 1'b0;
        $display("test serial_connector finished");
        // Enable low: a request that would be granted leaves every answer frozen
        @(negedge clk);
        clk_en = 1'b0;
        host_u.send(6'h20, 1'b0, 1'b1);
        chk({ser_gr, ser_rf, rd_gr}, 16'h0000);
        clk_en = 1'b1;
        $display("test clock_enable finished");
        tally_and_finish();
    end
endmodule
